/* design/ues_ep0_top.sv */
/*
 * EP0 setup handshake: Wishbone registers, NAK hold, IN answer logic.
 * Assumes a receive engine on clk_i giving token pulses and a busy level
 * covering each whole token, and a serializer that ends data with a pulse.
 */
// The address map and the Wishbone slave port are this design's own decisions.
// Summary of operation
// - SETUP for IN sets flag, raises interrupt
// - IN tokens NAKed while flag set
// - Flag clear in token CRC is harmless
// - Whole CRC bit interval is safe
// - Module enable low resets transmit state, event flags and hold; mask and buffer enables keep their values
// - No status flags endless transmit
// - Flag clear suppressed while buffers disabled
// - Disabled IN buffer leaves IN tokens unanswered
`timescale 1ns/10ps
`include "ues_consts.svh"

module ues_ep0_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        tok_busy_i,
    input  wire logic        tok_setup_i,
    input  wire logic        setup_dir_in_i,
    input  wire logic        tok_in_i,
    input  wire logic        tx_end_i,
    output logic             hs_nak_o,
    output logic             tx_start_o,
    output logic             tx_active_o,
    output logic             irq_o
);
    import ues_pkg::*;

    localparam int TX_LIMIT = `UES_TX_MAX_CYC;

    ues_top_st_t         s_r;
    ues_top_st_t         s_nxt;
    logic [`UES_NEV-1:0] ev_set;
    logic [`UES_NEV-1:0] irq_status;
    logic [`UES_NEV-1:0] irq_mask;
    logic                hold;
    logic                bufs_on;
    logic                bus_req;
    logic                wr_fire;
    logic                w1c_we;
    logic                mask_we;
    logic [31:0]         rd_data;

    ////////////////////////////////////////////////////////////////////////
    // Register decode

    function automatic logic reg_hit(input logic [7:0] adr,
                                     input logic [7:0] off);
        return {adr[7:2], 2'b00} == off;
    endfunction

    assign bus_req = wb_cyc_i & wb_stb_i;
    assign wr_fire = bus_req & wb_we_i & s_r.ack & wb_sel_i[0];
    assign w1c_we  = wr_fire & reg_hit(wb_adr_i, `UES_OFF_IFLAGS);
    assign mask_we = wr_fire & reg_hit(wb_adr_i, `UES_OFF_IMASK);
    assign bufs_on = s_r.in_en & s_r.out_en;

    always_comb begin
        rd_data = 32'h0000_0000;
        if (reg_hit(wb_adr_i, `UES_OFF_CTRL)) begin
            rd_data[`UES_BIT_EN] = s_r.ctrl_en;
        end
        if (reg_hit(wb_adr_i, `UES_OFF_IN_CFG)) begin
            rd_data[`UES_BIT_BUFEN] = s_r.in_en;
        end
        if (reg_hit(wb_adr_i, `UES_OFF_OUT_CFG)) begin
            rd_data[`UES_BIT_BUFEN] = s_r.out_en;
        end
        if (reg_hit(wb_adr_i, `UES_OFF_IFLAGS)) begin
            rd_data[`UES_NEV-1:0] = irq_status;
        end
        if (reg_hit(wb_adr_i, `UES_OFF_IMASK)) begin
            rd_data[`UES_NEV-1:0] = irq_mask;
        end
        if (reg_hit(wb_adr_i, `UES_OFF_STATUS)) begin
            rd_data[`UES_BIT_HOLD]  = hold;
            rd_data[`UES_BIT_TXACT] = s_r.tx_active;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Events

    always_comb begin
        ev_set = '0;
        ev_set[`UES_EV_SETUP]  = s_r.ctrl_en & tok_setup_i
                               & setup_dir_in_i;
        ev_set[`UES_EV_TXDONE] = s_r.ctrl_en & tx_end_i
                               & (s_r.state == TX_DATA);
        ev_set[`UES_EV_NAK]    = s_r.ctrl_en & s_r.hs_nak;
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        s_nxt          = s_r;
        s_nxt.ack      = bus_req & ~s_r.ack;
        s_nxt.hs_nak   = 1'b0;
        s_nxt.tx_start = 1'b0;
        if (bus_req & ~s_r.ack) begin
            s_nxt.dat = rd_data;
        end
        if (wr_fire) begin
            if (reg_hit(wb_adr_i, `UES_OFF_CTRL)) begin
                s_nxt.ctrl_en = wb_dat_i[`UES_BIT_EN];
            end
            if (reg_hit(wb_adr_i, `UES_OFF_IN_CFG)) begin
                s_nxt.in_en = wb_dat_i[`UES_BIT_BUFEN];
            end
            if (reg_hit(wb_adr_i, `UES_OFF_OUT_CFG)) begin
                s_nxt.out_en = wb_dat_i[`UES_BIT_BUFEN];
            end
        end
        if (!s_r.ctrl_en) begin
            // Transmit logic held in idle while disabled
            s_nxt.state     = TX_IDLE;
            s_nxt.tx_active = 1'b0;
            s_nxt.tx_cnt    = '0;
        end else begin
            case (s_r.state)
                TX_IDLE: begin
                    if (tok_in_i && s_r.in_en) begin
                        if (hold) begin
                            s_nxt.hs_nak = 1'b1;
                            s_nxt.state  = TX_NAK;
                        end else begin
                            // Data stage once software released hold
                            s_nxt.tx_start  = 1'b1;
                            s_nxt.tx_active = 1'b1;
                            s_nxt.tx_cnt    = '0;
                            s_nxt.state     = TX_DATA;
                        end
                    end
                    // Buffer disabled: token left unanswered
                end
                TX_NAK: begin
                    s_nxt.state = TX_IDLE;
                end
                TX_DATA: begin
                    s_nxt.tx_cnt = s_r.tx_cnt + `UES_CNT_W'(1);
                    if (tx_end_i || tok_setup_i) begin
                        s_nxt.state     = TX_IDLE;
                        s_nxt.tx_active = 1'b0;
                    end else if (s_r.tx_cnt ==
                                 `UES_CNT_W'(TX_LIMIT - 1)) begin
                        // Silent abort, no flag raised
                        s_nxt.state     = TX_IDLE;
                        s_nxt.tx_active = 1'b0;
                    end
                end
                default: begin
                    s_nxt.state     = TX_IDLE;
                    s_nxt.tx_active = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Submodules

    ues_irq u_irq (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .clr_all_i (~s_r.ctrl_en),
        .set_i     (ev_set),
        .w1c_we_i  (w1c_we),
        .w1c_i     (wb_dat_i[`UES_NEV-1:0]),
        .mask_we_i (mask_we),
        .mask_i    (wb_dat_i[`UES_NEV-1:0]),
        .status_o  (irq_status),
        .mask_o    (irq_mask),
        .irq_o     (irq_o)
    );

    ues_gate u_gate (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .en_i       (s_r.ctrl_en),
        .bufs_on_i  (bufs_on),
        .tok_busy_i (tok_busy_i),
        .flag_i     (irq_status[`UES_EV_SETUP]),
        .hold_o     (hold)
    );

    assign wb_dat_o    = s_r.dat;
    assign wb_ack_o    = s_r.ack;
    assign hs_nak_o    = s_r.hs_nak;
    assign tx_start_o  = s_r.tx_start;
    assign tx_active_o = s_r.tx_active;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence seq_setup_in;
        s_r.ctrl_en && tok_setup_i && setup_dir_in_i
            && irq_mask[`UES_EV_SETUP] && !mask_we;
    endsequence

    sequence seq_flag_irq;
        irq_status[`UES_EV_SETUP] && irq_o;
    endsequence

    sequence seq_in_idle;
        s_r.ctrl_en && tok_in_i && s_r.in_en && (s_r.state == TX_IDLE);
    endsequence

    a_setup_irq: assert property (seq_setup_in |=> seq_flag_irq)
        else $error("setup did not set flag and interrupt");

    a_nak_hold: assert property (
        seq_in_idle ##0 hold |=> hs_nak_o && !tx_start_o ##1 !hs_nak_o)
        else $error("IN token not NAKed while flag held");

    a_data_release: assert property (
        seq_in_idle ##0 !hold |=> tx_start_o && tx_active_o && !hs_nak_o)
        else $error("IN token not answered with data after release");

    a_hold_in_token: assert property (
        tok_busy_i && hold && s_r.ctrl_en |=> hold)
        else $error("hold released during token reception");

    a_clear_span: assert property (
        $fell(hold) && $past(s_r.ctrl_en) |-> !$past(tok_busy_i))
        else $error("hold cleared while token busy");

    a_disable_reset: assert property (
        !s_r.ctrl_en |=> (s_r.state == TX_IDLE) && !tx_active_o
            && (irq_status == '0) && !hold ##1 !irq_o)
        else $error("disable did not reset module");

    a_tx_bounded: assert property (
        tx_active_o |-> s_r.tx_cnt < `UES_CNT_W'(TX_LIMIT))
        else $error("transmit ran past its limit");

    a_gate_off: assert property (
        hold && s_r.ctrl_en && !bufs_on |=> hold)
        else $error("flag clear not suppressed with buffers off");

    a_orphan_tok: assert property (
        tok_in_i && !s_r.in_en |=> !hs_nak_o && !tx_start_o)
        else $error("token answered with buffer disabled");

    a_ack_pulse: assert property (
        bus_req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single cycle pulse");

    a_dat_hold: assert property (
        !(bus_req && !wb_ack_o) |=> $stable(wb_dat_o))
        else $error("read data changed without a request");

    sequence seq_hold_free;
        s_r.ctrl_en && hold && !irq_status[`UES_EV_SETUP]
            && bufs_on && !tok_busy_i;
    endsequence

    a_hold_follow: assert property (
        s_r.ctrl_en && irq_status[`UES_EV_SETUP] |=> hold)
        else $error("hold did not follow setup flag");

    a_hold_release: assert property (seq_hold_free |=> !hold)
        else $error("hold not released between tokens");

    a_nak_flag: assert property (
        s_r.ctrl_en && hs_nak_o |=> irq_status[`UES_EV_NAK])
        else $error("NAK sent without event flag");

    a_done_flag: assert property (
        s_r.ctrl_en && tx_end_i && (s_r.state == TX_DATA)
            |=> irq_status[`UES_EV_TXDONE] && !tx_active_o)
        else $error("data end not flagged");

    a_setup_abort: assert property (
        s_r.ctrl_en && tok_setup_i && (s_r.state == TX_DATA)
            |=> !tx_active_o)
        else $error("setup did not abort transmit");

    a_irq_level: assert property (
        irq_o == |(irq_status & irq_mask))
        else $error("interrupt level wrong");

endmodule

/* design/ues_consts.svh */
/*
 * Offsets, field positions and timing counts of the EP0 setup handshake.
 * Assumes a 50 MHz system clock and a byte-addressed Wishbone slave.
 */
`ifndef UES_CONSTS_SVH
`define UES_CONSTS_SVH

`define UES_OFF_CTRL     8'h00
`define UES_OFF_IN_CFG   8'h04
`define UES_OFF_OUT_CFG  8'h08
`define UES_OFF_IFLAGS   8'h0C
`define UES_OFF_IMASK    8'h10
`define UES_OFF_STATUS   8'h14

`define UES_BIT_EN       0
`define UES_BIT_BUFEN    0
`define UES_BIT_HOLD     0
`define UES_BIT_TXACT    1

`define UES_EV_SETUP     0
`define UES_EV_TXDONE    1
`define UES_EV_NAK       2
`define UES_NEV          3

`define UES_CLK_NS       20
`define UES_TX_MAX_NS    60000
`define UES_TX_MAX_CYC   (`UES_TX_MAX_NS / `UES_CLK_NS)
`define UES_CNT_W        12

`endif

/* design/ues_pkg.sv */
/*
 * Types of the EP0 setup handshake: transmit states and module state.
 * Assumes ues_consts.svh on the include path.
 */
`include "ues_consts.svh"

package ues_pkg;

    typedef enum logic [1:0] {
        TX_IDLE,
        TX_NAK,
        TX_DATA
    } ues_tx_state_t;

    typedef struct packed {
        logic                  ack;
        logic [31:0]           dat;
        logic                  ctrl_en;
        logic                  in_en;
        logic                  out_en;
        ues_tx_state_t         state;
        logic [`UES_CNT_W-1:0] tx_cnt;
        logic                  hs_nak;
        logic                  tx_start;
        logic                  tx_active;
    } ues_top_st_t;

    typedef struct packed {
        logic [`UES_NEV-1:0]   status;
        logic [`UES_NEV-1:0]   mask;
        logic                  irq;
    } ues_irq_st_t;

    typedef struct packed {
        logic                  hold;
    } ues_gate_st_t;

endpackage

/* design/ues_irq.sv */
/*
 * Sticky event flags, write-one-to-clear, with mask and level interrupt.
 * Assumes one clock, synchronous active-high reset.
 */
`timescale 1ns/10ps
`include "ues_consts.svh"

module ues_irq (
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic                clr_all_i,
    input  wire logic [`UES_NEV-1:0] set_i,
    input  wire logic                w1c_we_i,
    input  wire logic [`UES_NEV-1:0] w1c_i,
    input  wire logic                mask_we_i,
    input  wire logic [`UES_NEV-1:0] mask_i,
    output logic      [`UES_NEV-1:0] status_o,
    output logic      [`UES_NEV-1:0] mask_o,
    output logic                     irq_o
);
    import ues_pkg::*;

    ues_irq_st_t s_r;
    ues_irq_st_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (w1c_we_i) begin
            s_nxt.status = s_r.status & ~w1c_i;
        end
        // Set wins over a write-one clear in the same cycle; clr_all_i wins over both
        s_nxt.status = s_nxt.status | set_i;
        if (mask_we_i) begin
            s_nxt.mask = mask_i;
        end
        if (clr_all_i) begin
            s_nxt.status = '0;
        end
        s_nxt.irq = |(s_nxt.status & s_nxt.mask);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign status_o = s_r.status;
    assign mask_o   = s_r.mask;
    assign irq_o    = s_r.irq;

endmodule

/* design/ues_gate.sv */
/*
 * NAK hold as seen by the transmit logic, set one cycle after the flag, cleared by software only between tokens, or at once by module disable.
 * Assumes token-busy from the receive engine on the same clock.
 */
`timescale 1ns/10ps
`include "ues_consts.svh"

module ues_gate (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic en_i,
    input  wire logic bufs_on_i,
    input  wire logic tok_busy_i,
    input  wire logic flag_i,
    output logic      hold_o
);
    import ues_pkg::*;

    ues_gate_st_t s_r;
    ues_gate_st_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (!en_i) begin
            s_nxt.hold = 1'b0;
        end else if (flag_i) begin
            s_nxt.hold = 1'b1;
        end else if (bufs_on_i && !tok_busy_i) begin
            // Clear applied only with buffers on and no token in flight
            s_nxt.hold = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign hold_o = s_r.hold;

endmodule

/* tb/ues_host_model.sv */
/*
 * Host-side stand-in: SETUP and IN token source, data serializer end.
 * Assumes the block's clock and synchronous active-high reset.
 */
`timescale 1ns/10ps

module ues_host_model #(
    parameter int TOK_CYC = 5
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       go_i,
    input  wire logic [1:0] cmd_i,
    input  wire logic [7:0] dly_i,
    input  wire logic       tx_start_i,
    output logic            tok_busy_o,
    output logic            tok_setup_o,
    output logic            setup_dir_in_o,
    output logic            tok_in_o,
    output logic            tx_end_o,
    output logic            done_o
);
    logic [3:0] cnt_r;
    logic [1:0] cmd_r;
    logic [7:0] dcnt_r;
    logic       dact_r;
    logic       tgl_r;

    // Token pulses land in the last busy cycle
    assign tok_busy_o     = cnt_r != 4'h0;
    assign done_o         = cnt_r == 4'h0;
    assign tok_setup_o    = cnt_r == 4'h1 && cmd_r[0];
    assign tok_in_o       = cnt_r == 4'h1 && cmd_r == 2'h2;
    // Direction toggles when not qualified by a SETUP pulse
    assign setup_dir_in_o = tok_setup_o ? cmd_r == 2'h1 : tgl_r;
    assign tx_end_o       = dact_r && dcnt_r == 8'h00;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r  <= 4'h0;
            cmd_r  <= 2'h0;
            dcnt_r <= 8'h00;
            dact_r <= 1'b0;
            tgl_r  <= 1'b0;
        end else begin
            tgl_r <= ~tgl_r;
            if (go_i && cnt_r == 4'h0) begin
                cnt_r <= 4'(TOK_CYC);
                cmd_r <= cmd_i;
            end else if (cnt_r != 4'h0) begin
                cnt_r <= cnt_r - 4'h1;
            end
            if (tx_start_i) begin
                dact_r <= 1'b1;
                dcnt_r <= dly_i;
            end else if (dact_r) begin
                dact_r <= dcnt_r != 8'h00;
                dcnt_r <= dcnt_r - 8'h01;
            end
        end
    end
endmodule

/* tb/ues_ep0_top_test.sv */
/*
 * Self-checking bench of the EP0 setup handshake block.
 * Assumes ues_consts.svh and ues_host_model on the compile list.
 */
`timescale 1ns/10ps
`include "ues_consts.svh"

module ues_ep0_top_test;
    logic        clk, rst, cyc, stb, we, go, ack, nak, tstart, tact, irq;
    logic        busy, setup, dir_in, tok_in, tx_end, done;
    logic [7:0]  adr, dly;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, seed;
    logic [1:0]  cmd;
    logic [31:0] rd_q[$];
    logic [1:0]  ans_q[$];
    int          bad_count, check_count;

    ues_ep0_top u_dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .tok_busy_i(busy), .tok_setup_i(setup), .setup_dir_in_i(dir_in),
        .tok_in_i(tok_in), .tx_end_i(tx_end), .hs_nak_o(nak),
        .tx_start_o(tstart), .tx_active_o(tact), .irq_o(irq));

    ues_host_model u_host (.clk_i(clk), .rst_i(rst), .go_i(go),
        .cmd_i(cmd), .dly_i(dly), .tx_start_i(tstart), .tok_busy_o(busy),
        .tok_setup_o(setup), .setup_dir_in_o(dir_in), .tok_in_o(tok_in),
        .tx_end_o(tx_end), .done_o(done));

    ////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return 8'(seed & 32'h0000000F);
    endfunction

    task chk(input string what, input logic [31:0] exp,
             input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [31:0] exp);
        rd_q.push_back(exp);
        bus(1'b0, a, 32'h00000000);
    endtask

    // Answer codes: 1 handshake NAK, 2 data packet
    task tok(input logic [1:0] c, input logic [1:0] ans,
             input logic [7:0] d);
        int n;
        if (ans != 2'h0) ans_q.push_back(ans);
        repeat (rnd() % 3) @(posedge clk);
        @(posedge clk);
        go  <= 1'b1;
        cmd <= c;
        dly <= d;
        @(posedge clk);
        go <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (done !== 1'b1 && n < 20);
        repeat (2) @(posedge clk);
    endtask

    task idle();
        int n;
        n = 0;
        while (tact !== 1'b0 && n < 300) begin
            @(posedge clk);
            n++;
        end
        chk("tx_active", 32'h0, {31'h0, tact});
    endtask

    task complete_run();
        $display("checks %0d errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0) begin
            if (rd_q.size() == 0) chk("read queue", 32'h1, 32'h0);
            else chk("read data", rd_q.pop_front(), rdat);
        end
        if (nak === 1'b1 || tstart === 1'b1) begin
            if (ans_q.size() == 0) begin
                chk("answer", 32'h0, {30'h0, tstart, nak});
            end else begin
                chk("answer", {30'h0, ans_q.pop_front()},
                    {30'h0, tstart, nak});
            end
        end
    end

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        complete_run();
    end

    initial begin
        {cyc, stb, we, go, adr, dly, cmd, wdat} = '0;
        sel  = 4'hF;
        seed = 32'h0000EBDB;
        rst  = 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd(`UES_OFF_CTRL, 32'h0);
        rd(`UES_OFF_IFLAGS, 32'h0);
        bus(1'b1, 8'h1C, 32'hFF);
        rd(8'h1C, 32'h0);
        bus(1'b1, `UES_OFF_CTRL, 32'h1);
        bus(1'b1, `UES_OFF_IN_CFG, 32'h1);
        bus(1'b1, `UES_OFF_OUT_CFG, 32'h1);
        // Write with byte lane zero off is ignored
        sel <= 4'hE;
        bus(1'b1, `UES_OFF_CTRL, 32'h0);
        sel <= 4'hF;
        rd(`UES_OFF_CTRL, 32'h1);
        tok(2'h3, 2'h0, 8'h00);
        rd(`UES_OFF_IFLAGS, 32'h0);
        tok(2'h1, 2'h0, 8'h00);
        rd(`UES_OFF_IFLAGS, 32'h1);
        chk("irq masked", 32'h0, {31'h0, irq});
        bus(1'b1, `UES_OFF_IMASK, 32'h7);
        repeat (2) @(posedge clk);
        chk("irq", 32'h1, {31'h0, irq});
        rd(`UES_OFF_STATUS, 32'h1);
        tok(2'h2, 2'h1, 8'h00);
        rd(`UES_OFF_IFLAGS, 32'h5);
        // Software clear lands while the token is still arriving
        fork
            tok(2'h2, 2'h1, 8'h00);
            begin
                @(posedge clk);
                bus(1'b1, `UES_OFF_IFLAGS, 32'h1);
            end
        join
        rd(`UES_OFF_IFLAGS, 32'h4);
        tok(2'h2, 2'h2, rnd());
        idle();
        rd(`UES_OFF_IFLAGS, 32'h6);
        bus(1'b1, `UES_OFF_IFLAGS, 32'h6);
        repeat (2) @(posedge clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        // Buffer enables low around the flag clear
        tok(2'h1, 2'h0, 8'h00);
        bus(1'b1, `UES_OFF_IN_CFG, 32'h0);
        bus(1'b1, `UES_OFF_OUT_CFG, 32'h0);
        bus(1'b1, `UES_OFF_IFLAGS, 32'h1);
        tok(2'h2, 2'h0, 8'h00);
        rd(`UES_OFF_STATUS, 32'h1);
        bus(1'b1, `UES_OFF_IN_CFG, 32'h1);
        bus(1'b1, `UES_OFF_OUT_CFG, 32'h1);
        tok(2'h2, 2'h2, rnd());
        idle();
        // Module disable in mid transmit
        tok(2'h2, 2'h2, 8'hC8);
        bus(1'b1, `UES_OFF_CTRL, 32'h0);
        rd(`UES_OFF_STATUS, 32'h0);
        rd(`UES_OFF_IFLAGS, 32'h0);
        repeat (210) @(posedge clk);
        bus(1'b1, `UES_OFF_CTRL, 32'h1);
        tok(2'h1, 2'h0, 8'h00);
        bus(1'b1, `UES_OFF_IFLAGS, 32'h1);
        tok(2'h2, 2'h2, rnd());
        idle();
        // SETUP in mid transmit aborts it with no flag
        tok(2'h2, 2'h2, 8'hC8);
        tok(2'h3, 2'h0, 8'h00);
        chk("tx abort", 32'h0, {31'h0, tact});
        rd(`UES_OFF_IFLAGS, 32'h2);
        complete_run();
    end
endmodule
